// ==== hdl/brs_pkg.sv ====
// constants, field layouts and state codes for the brown-out reset sequencer
// assumes a single 100 MHz system clock and a plain strobe register port
`default_nettype none
package brs_pkg;

  localparam int CLOCK_MHZ = 100;
  localparam int SETTLE_US = 20; // regulator_settle_time
  localparam int SETTLE_CYC = SETTLE_US * CLOCK_MHZ;
  localparam int FSCM_US = 100; // failsafe_monitor_delay
  localparam int FSCM_CYC = FSCM_US * CLOCK_MHZ;
  localparam int TIMER_W = 24;

  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] OFS_CAUSE = 4'h0; // reset_cause_register
  localparam logic [ADDR_W-1:0] OFS_OSC = 4'h1; // osc_control_register
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATE = 4'h5;

  // reset cause fields
  localparam int CAUSE_POR_BIT = 0;
  localparam int CAUSE_DIP_BIT = 1;
  localparam logic [1:0] CAUSE_RST = 2'h1; // power-on sets its own bit
  // osc control fields
  localparam int OSC_SEL_LSB = 0;
  localparam int OSC_KIND_LSB = 3;
  localparam int OSC_LOCK_BIT = 5;
  // config fields
  localparam int CFG_DELAY_EN_BIT = 0;
  localparam logic CFG_DELAY_EN_RST = 1'h1;
  // interrupt status and mask fields
  localparam int IRQ_W = 2;
  localparam int IRQ_DIP_BIT = 0;
  localparam int IRQ_RELEASE_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

  // initial_osc_select codes
  localparam logic [2:0] SEL_FAST_RC = 3'h0;
  localparam logic [2:0] SEL_FAST_RC_PLL = 3'h1;
  localparam logic [2:0] SEL_PRIMARY = 3'h2;
  localparam logic [2:0] SEL_PRIMARY_PLL = 3'h3;
  localparam logic [2:0] SEL_SECONDARY = 3'h4;
  // primary_osc_kind codes
  localparam logic [1:0] KIND_EXT_CLOCK = 2'h0;
  localparam logic [1:0] KIND_XTAL_LOW = 2'h1;
  localparam logic [1:0] KIND_XTAL_HIGH = 2'h2;
  localparam logic [1:0] KIND_OFF = 2'h3;

  typedef enum logic [4:0] {
    ST_DOWN = 5'h01,
    ST_SETTLE = 5'h02,
    ST_HOLD = 5'h04,
    ST_RUN = 5'h08,
    ST_DIP = 5'h10
  } brs_state_t;

endpackage
`default_nettype wire

// ==== hdl/brs_timer.sv ====
// one-shot down counter used for every hold interval of the sequencer
// assumes start is a one-cycle pulse on the system clock
`timescale 1ns/1ps
`default_nettype none
module brs_timer #(
  parameter int W = 24
) (
  input wire logic i_clock, // system clock
  input wire logic i_rstn, // async reset, active low
  input wire logic i_start, // load length, one-cycle pulse
  input wire logic [W-1:0] i_length, // interval in clock cycles
  output logic o_done // high while no interval is running
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // load on start, otherwise count down to zero and stay there
  always_comb begin
    next_count = count;
    if (i_start) begin
      next_count = i_length;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign o_done = (count == '0);

endmodule
`default_nettype wire

// ==== hdl/brownout_reset_sequencer.sv ====
// reset and start-up sequencer: regulator settle, dip reset, clock hold
// assumes asynchronous analog flags and straps, registers on a strobe port
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module brownout_reset_sequencer
  import brs_pkg::*;
#(
  parameter int STARTUP_CYCLES = 1024,
  parameter int POWER_UP_CYCLES = 4000,
  parameter int FSCM_CYCLES = FSCM_CYC
) (
  input wire logic i_clock, // 100 MHz system clock
  input wire logic i_rstn, // power-on reset, active low
  input wire logic i_supply_dip, // dip comparator, async level
  input wire logic i_power_down, // power-down request, async level
  input wire logic i_pll_locked, // pll settled flag, async level
  input wire logic [2:0] i_initial_osc_select, // strap field
  input wire logic [1:0] i_primary_osc_kind, // strap field
  input wire logic [ADDR_W-1:0] i_addr, // register address
  input wire logic [DATA_W-1:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [DATA_W-1:0] o_rdata, // read data, cycle after strobe
  output logic o_core_reset_n, // internal reset, active low
  output logic o_clock_hold, // system clock withheld
  output logic o_dip_reset, // one-cycle reset pulse on a dip
  output logic [2:0] o_osc_select, // clock source in use
  output logic o_irq // level interrupt
);

  localparam int SYNC_W = 8;

  // every analog flag and strap crosses in through two flip-flops
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_out;

  assign sync_raw = {i_supply_dip, i_power_down, i_pll_locked,
                     i_initial_osc_select, i_primary_osc_kind};

  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_sync
      always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
          sync_meta[g] <= 1'b0;
          sync_out[g] <= 1'b0;
        end else begin
          sync_meta[g] <= sync_raw[g];
          sync_out[g] <= sync_meta[g];
        end
      end
    end
  endgenerate

  logic dip;
  logic power_down;
  logic pll_locked;
  logic [2:0] strap_sel;
  logic [1:0] strap_kind;

  assign dip = sync_out[7];
  assign power_down = sync_out[6];
  assign pll_locked = sync_out[5];
  assign strap_sel = sync_out[4:2];
  assign strap_kind = sync_out[1:0];

  // sequencer state and the clock source latched at each reset
  brs_state_t state;
  brs_state_t next_state;
  logic [2:0] cur_sel;
  logic [2:0] next_cur_sel;
  logic [1:0] cur_kind;
  logic [1:0] next_cur_kind;
  logic delay_en;
  logic settle_done;
  logic startup_done;
  logic delay_done;
  logic settle_start;
  logic hold_start;
  logic osc_mode;
  logic pll_used;
  logic crystal;
  logic fscm_case;
  logic startup_needed;
  logic clock_ready;
  logic [TIMER_W-1:0] delay_len;

  // decode of the latched source fields
  always_comb begin
    osc_mode = (cur_sel == SEL_PRIMARY) || (cur_sel == SEL_PRIMARY_PLL) ||
               (cur_sel == SEL_SECONDARY);
    pll_used = (cur_sel == SEL_FAST_RC_PLL) || (cur_sel == SEL_PRIMARY_PLL);
    crystal = osc_mode && ((cur_kind == KIND_XTAL_LOW) ||
                           (cur_kind == KIND_XTAL_HIGH));
    fscm_case = !delay_en && crystal;
    // the fail-safe delay stands alone, so the start-up timer is not waited
    startup_needed = osc_mode && !fscm_case;
    clock_ready = (startup_done || !startup_needed) &&
                  (pll_locked || !pll_used);
    if (delay_en) begin
      delay_len = TIMER_W'(POWER_UP_CYCLES);
    end else if (crystal) begin
      delay_len = TIMER_W'(FSCM_CYCLES);
    end else begin
      delay_len = '0;
    end
  end

  // dip has top priority in every state except ST_DOWN, where it is ignored
  always_comb begin
    next_state = state;
    next_cur_sel = cur_sel;
    next_cur_kind = cur_kind;
    if (dip && state != ST_DOWN) begin
      next_state = ST_DIP;
    end else begin
      case (state)
        ST_DOWN: begin
          if (!power_down) begin
            next_state = ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (power_down) begin
            next_state = ST_DOWN;
          end else if (settle_done) begin
            next_state = ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (power_down) begin
            next_state = ST_DOWN;
          end else if (clock_ready && delay_done) begin
            next_state = ST_RUN;
          end
        end
        ST_RUN: begin
          if (power_down) begin
            next_state = ST_DOWN;
          end
        end
        ST_DIP: begin
          if (!dip) begin
            next_state = ST_HOLD;
          end
        end
        default: begin
          next_state = ST_DOWN;
        end
      endcase
    end
    // the source is taken from the straps whenever a hold phase begins
    if (next_state == ST_HOLD && state != ST_HOLD) begin
      next_cur_sel = strap_sel;
      next_cur_kind = strap_kind;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_DOWN;
      cur_sel <= SEL_FAST_RC;
      cur_kind <= KIND_OFF;
    end else begin
      state <= next_state;
      cur_sel <= next_cur_sel;
      cur_kind <= next_cur_kind;
    end
  end

  // timers load on the edge that enters their state
  assign settle_start = (next_state == ST_SETTLE) && (state != ST_SETTLE);
  assign hold_start = (next_state == ST_HOLD) && (state != ST_HOLD);

  brs_timer #(
    .W(TIMER_W)
  ) u_settle (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_start(settle_start),
    .i_length(TIMER_W'(SETTLE_CYC)),
    .o_done(settle_done)
  );

  brs_timer #(
    .W(TIMER_W)
  ) u_osc_startup (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_start(hold_start),
    .i_length(TIMER_W'(STARTUP_CYCLES)),
    .o_done(startup_done)
  );

  // source fields at entry are not latched yet, so length uses the straps
  logic [TIMER_W-1:0] entry_delay_len;
  logic entry_crystal;

  always_comb begin
    entry_crystal = ((strap_sel == SEL_PRIMARY) ||
                     (strap_sel == SEL_PRIMARY_PLL) ||
                     (strap_sel == SEL_SECONDARY)) &&
                    ((strap_kind == KIND_XTAL_LOW) ||
                     (strap_kind == KIND_XTAL_HIGH));
    if (delay_en) begin
      entry_delay_len = TIMER_W'(POWER_UP_CYCLES);
    end else if (entry_crystal) begin
      entry_delay_len = TIMER_W'(FSCM_CYCLES);
    end else begin
      entry_delay_len = delay_len & '0;
    end
  end

  brs_timer #(
    .W(TIMER_W)
  ) u_power_up (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_start(hold_start),
    .i_length(entry_delay_len),
    .o_done(delay_done)
  );

  // sequencer outputs, registered
  logic next_core_reset_n;
  logic next_clock_hold;
  logic next_dip_reset;

  always_comb begin
    next_core_reset_n = (next_state == ST_RUN);
    next_clock_hold = 1'b1;
    if (next_state == ST_RUN) begin
      next_clock_hold = 1'b0;
    end else if (state == ST_HOLD && next_state == ST_HOLD) begin
      next_clock_hold = !clock_ready;
    end
    next_dip_reset = (next_state == ST_DIP) && (state != ST_DIP);
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_core_reset_n <= 1'b0;
      o_clock_hold <= 1'b1;
      o_dip_reset <= 1'b0;
    end else begin
      o_core_reset_n <= next_core_reset_n;
      o_clock_hold <= next_clock_hold;
      o_dip_reset <= next_dip_reset;
    end
  end

  assign o_osc_select = cur_sel;

  // register file; power-on loads the cause bits to 1 (POR bit set), a zero write clears them
  logic [1:0] cause;
  logic [1:0] next_cause;
  logic next_delay_en;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] next_irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] next_irq_mask;
  logic [IRQ_W-1:0] irq_set;
  logic [DATA_W-1:0] next_rdata;

  assign irq_set[IRQ_DIP_BIT] = next_dip_reset;
  assign irq_set[IRQ_RELEASE_BIT] = (next_state == ST_RUN) && (state != ST_RUN);

  always_comb begin
    next_cause = cause;
    next_delay_en = delay_en;
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    next_rdata = '0; // unmapped addresses read zero
    if (i_wr) begin
      case (i_addr)
        OFS_CAUSE: begin
          next_cause = cause & i_wdata[1:0]; // zero writes clear
        end
        OFS_CONFIG: begin
          next_delay_en = i_wdata[CFG_DELAY_EN_BIT];
        end
        OFS_IRQ_MASK: begin
          next_irq_mask = i_wdata[IRQ_W-1:0];
        end
        default: begin
          next_cause = cause;
        end
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        OFS_CAUSE: begin
          next_rdata[1:0] = cause;
        end
        OFS_OSC: begin
          next_rdata[OSC_SEL_LSB +: 3] = cur_sel;
          next_rdata[OSC_KIND_LSB +: 2] = cur_kind;
          next_rdata[OSC_LOCK_BIT] = pll_locked;
        end
        OFS_CONFIG: begin
          next_rdata[CFG_DELAY_EN_BIT] = delay_en;
        end
        OFS_IRQ_STAT: begin
          next_rdata[IRQ_W-1:0] = irq_stat;
          next_irq_stat = '0; // read clears
        end
        OFS_IRQ_MASK: begin
          next_rdata[IRQ_W-1:0] = irq_mask;
        end
        OFS_STATE: begin
          next_rdata[4:0] = state;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
    // a set in the clearing cycle wins so no event is lost
    next_irq_stat = next_irq_stat | irq_set;
    if (next_dip_reset) begin
      next_cause[CAUSE_DIP_BIT] = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      cause <= CAUSE_RST;
      delay_en <= CFG_DELAY_EN_RST;
      irq_stat <= '0;
      irq_mask <= IRQ_MASK_RST;
      o_rdata <= '0;
    end else begin
      cause <= next_cause;
      delay_en <= next_delay_en;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      o_rdata <= next_rdata;
    end
  end

  // level interrupt; registered so it is glitch free
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(next_irq_stat & next_irq_mask);
    end
  end

endmodule
`default_nettype wire

// ==== dv/brs_assertions.sv ====
// assertion checker for the brown-out reset sequencer, bound to its top
// assumes one clock domain; the shortest hold after a dip exceeds 8 cycles
`timescale 1ns/1ps
`default_nettype none
module brs_checker
  import brs_pkg::*;
(
  input wire logic i_clock, // system clock
  input wire logic i_rstn, // reset, active low
  input wire logic i_supply_dip, // dip comparator
  input wire logic i_power_down, // power-down request
  input wire logic i_pll_locked, // pll settled flag
  input wire logic o_core_reset_n, // internal reset
  input wire logic o_clock_hold, // clock withheld
  input wire logic o_dip_reset, // dip reset pulse
  input wire logic [2:0] o_osc_select // clock source
);
  logic [11:0] settle_cnt;
  logic dip_seen;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  // cycles since power came back; a dip may legally cut the settle short
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      settle_cnt <= 12'h0;
      dip_seen <= 1'b0;
    end else if (i_power_down) begin
      settle_cnt <= 12'h0;
      dip_seen <= 1'b0;
    end else begin
      settle_cnt <= (settle_cnt == 12'hfff) ? settle_cnt : settle_cnt + 12'h1;
      dip_seen <= dip_seen | o_dip_reset;
    end
  end

  a_settle_first: assert property (
    $rose(o_core_reset_n) |-> (int'(settle_cnt) >= SETTLE_CYC) || dip_seen)
    else $error("core released before the regulator settled");
  a_dip_pulse_reset: assert property (o_dip_reset |-> !o_core_reset_n)
    else $error("dip pulse without internal reset");
  a_dip_pulse_once: assert property (o_dip_reset |=> !o_dip_reset)
    else $error("dip pulse longer than one cycle");
  a_dip_any_mode: assert property (
    $rose(i_supply_dip) && o_core_reset_n |-> ##[1:5] o_dip_reset)
    else $error("running device ignored a dip");
  a_dip_holds_reset: assert property (i_supply_dip [*5] |-> !o_core_reset_n)
    else $error("internal reset free while dip persists");
  a_delay_after_dip: assert property (
    o_dip_reset |=> !o_core_reset_n [*8])
    else $error("power-up delay cut short");
  a_pll_before_run: assert property (
    $rose(o_core_reset_n) && (o_osc_select == SEL_FAST_RC_PLL ||
    o_osc_select == SEL_PRIMARY_PLL) |-> $past(i_pll_locked, 2))
    else $error("released without pll lock");
  a_clock_in_run: assert property (o_core_reset_n |-> !o_clock_hold)
    else $error("clock withheld after release");
  a_osc_steady: assert property (
    o_core_reset_n && $past(o_core_reset_n) |-> $stable(o_osc_select))
    else $error("clock source moved while running");
endmodule

bind brownout_reset_sequencer brs_checker u_chk (
  .i_clock(i_clock),
  .i_rstn(i_rstn),
  .i_supply_dip(i_supply_dip),
  .i_power_down(i_power_down),
  .i_pll_locked(i_pll_locked),
  .o_core_reset_n(o_core_reset_n),
  .o_clock_hold(o_clock_hold),
  .o_dip_reset(o_dip_reset),
  .o_osc_select(o_osc_select)
);
`default_nettype wire

// ==== dv/brownout_reset_sequencer_tb_top.sv ====
// self-checking bench for the brown-out reset sequencer
// assumes shortened timer parameters and the strobe register port
`timescale 1ns/1ps
`default_nettype none
module brownout_reset_sequencer_tb_top
  import brs_pkg::*;
;
  // start-up timer longest, fail-safe shortest, so each hold shows in the timing
  localparam int STARTUP_N = 16;
  localparam int DELAY_N = 10;
  localparam int FSCM_N = 6;
  logic clk, rstn, dip, pdn, lock, wr, rd, core_n, hold, dip_rst, irq;
  logic [2:0] sel, osc;
  logic [1:0] kind;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  int fails = 0;
  int n_checks = 0;
  int n;

  brownout_reset_sequencer #(.STARTUP_CYCLES(STARTUP_N), .POWER_UP_CYCLES(DELAY_N),
    .FSCM_CYCLES(FSCM_N)) uut (
    .i_clock(clk), .i_rstn(rstn), .i_supply_dip(dip), .i_power_down(pdn),
    .i_pll_locked(lock), .i_initial_osc_select(sel), .i_primary_osc_kind(kind),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_core_reset_n(core_n), .o_clock_hold(hold), .o_dip_reset(dip_rst),
    .o_osc_select(osc), .o_irq(irq));

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask

  // bounded wait for release; n counts cycles waited
  task automatic wait_run(input int lim);
    n = 0;
    while (core_n !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    // a release on the last allowed cycle still counts as a release
    if (core_n !== 1'b1) begin
      fails++;
      report_and_stop();
    end
  endtask

  // straps settle first so the synchronisers see them before the dip
  task automatic dip_pulse(input logic [2:0] s, input logic [1:0] k);
    int seen;
    seen = 0;
    @(posedge clk);
    sel <= s;
    kind <= k;
    repeat (4) @(posedge clk);
    dip <= 1'b1;
    repeat (8) begin
      @(posedge clk);
      #1 if (dip_rst === 1'b1) seen++;
    end
    chk(16'(seen), 16'h1);
    chk(core_n, 1'b0);
    @(posedge clk);
    dip <= 1'b0;
  endtask

  // release lands lo cycles after hold entry, plus two sync edges and two state edges;
  // the tight window tells the start-up timer, power-up delay and fail-safe delay apart
  task automatic run_check(input int lo, input logic [2:0] s);
    wait_run(lo + 40);
    chk(n >= lo + 3 && n <= lo + 5, 1'b1);
    chk(osc, s);
    chk(hold, 1'b0);
  endtask

  initial begin
    {rstn, dip, pdn, wr, rd, sel, kind, addr, wdata} <= '0;
    lock <= 1'b1;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    wait_run(3000);
    chk(n >= SETTLE_CYC, 1'b1);
    rd_reg(OFS_CAUSE, 16'h1);
    rd_reg(OFS_CONFIG, 16'h1);
    rd_reg(4'hf, 16'h0);
    rd_reg(OFS_STATE, 16'h8);
    rd_reg(OFS_IRQ_STAT, 16'h2);
    $display("power-on test done");
    wr_reg(OFS_IRQ_MASK, 16'h1);
    // oscillator modes (codes 2 to 4) wait for the start-up timer, the rest for the delay
    for (int i = 0; i < 5; i++) begin
      dip_pulse(3'(i), KIND_XTAL_HIGH);
      run_check((i >= 2) ? STARTUP_N : DELAY_N, 3'(i));
    end
    chk(irq, 1'b1);
    rd_reg(OFS_CAUSE, 16'h3);
    rd_reg(OFS_IRQ_STAT, 16'h3);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0);
    wr_reg(OFS_CAUSE, 16'h1);
    wr_reg(OFS_STATE, 16'h1);
    rd_reg(OFS_CAUSE, 16'h1);
    rd_reg(OFS_STATE, 16'h8);
    $display("dip and source test done");
    @(posedge clk);
    lock <= 1'b0;
    dip_pulse(SEL_PRIMARY_PLL, KIND_XTAL_HIGH);
    repeat (40) @(posedge clk);
    #1 chk(core_n, 1'b0);
    chk(hold, 1'b1);
    @(posedge clk);
    lock <= 1'b1;
    wait_run(20);
    chk(hold, 1'b0);
    // select 3, kind 2 and the settled flag in bit 5
    rd_reg(OFS_OSC, 16'h33);
    $display("pll test done");
    wr_reg(OFS_CONFIG, 16'h0);
    dip_pulse(SEL_PRIMARY, KIND_XTAL_LOW);
    run_check(FSCM_N, SEL_PRIMARY);
    rd_reg(OFS_CAUSE, 16'h3);
    // an external clock is no crystal, so only the start-up timer holds
    dip_pulse(SEL_PRIMARY, KIND_EXT_CLOCK);
    run_check(STARTUP_N, SEL_PRIMARY);
    $display("fail-safe test done");
    @(posedge clk);
    pdn <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk(core_n, 1'b0);
    @(posedge clk);
    pdn <= 1'b0;
    wait_run(3000);
    chk(n >= SETTLE_CYC, 1'b1);
    rd_reg(OFS_CAUSE, 16'h3);
    $display("power-down test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
